//--- common/csm_defs.svh
`ifndef CSM_DEFS_SVH
`define CSM_DEFS_SVH

// sizes
`define N_FIFO          4
`define N_SLOT          4
`define N_CHAN          16
`define N_LINE          8
`define CHAN_W          4

// frame timing: one byte per channel every 125 us at a 20 ns clock
`define FRAME_NS        125000
`define CLK_PERIOD_NS   20
`define FRAME_CYCLES    (`FRAME_NS / `CLK_PERIOD_NS)
`define FRAME_CNT_W     16

// register byte addresses
`define REG_CTRL        8'h00
`define REG_STAT        8'h04
`define REG_MASK        8'h08
`define REG_RSV         8'h0c
`define GRP_TXF         4'h1
`define GRP_RXF         4'h2
`define GRP_TXS         4'h3
`define GRP_RXS         4'h4

// field layouts and reset values
`define CTRL_CSM_BIT    0
`define STAT_W          5
`define STAT_FRAME_BIT  4
`define FIFO_CFG_W      12
`define SLOT_CFG_W      7
`define FIFO_CFG_RST    12'h000
`define SLOT_CFG_RST    7'h00

// byte patterns
`define FILL_HDLC       8'h7e
`define FILL_ONES       8'hff
`define IDLE_BYTE       8'hff

`endif

//--- common/csm_pkg.sv
package csm_pkg;

  typedef logic [7:0] byte_t;

  // per-fifo routing and framing setup, lsb first: number, direction,
  // bit order, framing, fill select, interrupt setting, line-path flag
  typedef struct packed {
    logic       link;
    logic [2:0] irq_sel;
    logic       iff_ones;
    logic       transparent;
    logic       rev;
    logic       dir;
    logic [3:0] num;
  } fifo_cfg_t;

  // per-slot setup: pin routing, channel direction, channel number
  typedef struct packed {
    logic [1:0] rout;
    logic       dir;
    logic [3:0] num;
  } slot_cfg_t;

endpackage : csm_pkg

//--- common/tx_byte_if.sv
interface tx_byte_if;
  csm_pkg::byte_t data;
  logic           valid;
  logic           rev;
  logic           transparent;
  logic           iff_ones;
  csm_pkg::byte_t out_byte;

  modport core (
    output data,
    output valid,
    output rev,
    output transparent,
    output iff_ones,
    input  out_byte
  );

  modport gen (
    input  data,
    input  valid,
    input  rev,
    input  transparent,
    input  iff_ones,
    output out_byte
  );
endinterface : tx_byte_if

//--- rtl/csm_channel_routing.sv
// The Wishbone register port and the register offsets were chosen for this implementation.
`include "csm_defs.svh"

module csm_channel_routing #(
  parameter int FRAME_CYCLES = `FRAME_CYCLES
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // wishbone slave
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [7:0]               adr_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  // interrupt and frame marker
  output logic                          irq_o,
  output logic                          frame_o,
  // host-side fifos
  input  wire logic [`N_FIFO-1:0][7:0]  tx_fifo_data_i,
  input  wire logic [`N_FIFO-1:0]       tx_fifo_valid_i,
  output logic      [`N_FIFO-1:0]       tx_fifo_pop_o,
  input  wire logic [`N_FIFO-1:0]       rx_fifo_full_i,
  output logic      [`N_FIFO-1:0]       rx_fifo_push_o,
  output logic      [`N_FIFO-1:0][7:0]  rx_fifo_data_o,
  // line interface channel bytes
  input  wire logic [`N_LINE-1:0][7:0]  line_rx_i,
  output logic      [`N_LINE-1:0][7:0]  line_tx_o,
  // pcm slot bytes on the two data pins
  input  wire logic [`N_SLOT-1:0][7:0]  pcm_rx_one_i,
  input  wire logic [`N_SLOT-1:0][7:0]  pcm_rx_two_i,
  output logic      [`N_SLOT-1:0][7:0]  pcm_tx_one_o,
  output logic      [`N_SLOT-1:0]       pcm_tx_one_oe_o,
  output logic      [`N_SLOT-1:0][7:0]  pcm_tx_two_o,
  output logic      [`N_SLOT-1:0]       pcm_tx_two_oe_o
);

  logic                                  csm_r;
  logic [`STAT_W-1:0]                    stat_r;
  logic [`STAT_W-1:0]                    mask_r;
  csm_pkg::fifo_cfg_t [`N_FIFO-1:0]      txf_r;
  csm_pkg::fifo_cfg_t [`N_FIFO-1:0]      rxf_r;
  csm_pkg::slot_cfg_t [`N_SLOT-1:0]      txs_r;
  csm_pkg::slot_cfg_t [`N_SLOT-1:0]      rxs_r;
  logic [`FRAME_CNT_W-1:0]               frame_cnt_r;
  logic                                  tick;
  logic                                  wr_stb;
  logic [15:0]                           rd_nxt;
  logic [`N_FIFO-1:0]                    tx_en;
  logic [`N_FIFO-1:0]                    rx_en;
  csm_pkg::byte_t [`N_FIFO-1:0]          tx_byte;
  csm_pkg::byte_t [`N_SLOT-1:0]          rx_slot_byte;
  logic [`N_LINE-1:0]                    tx_link_ch;
  logic [`N_LINE-1:0]                    rx_link_ch;
  logic [`N_LINE-1:0]                    link_ok;
  logic [`N_LINE-1:0]                    line_rsv;
  logic [2*`N_FIFO-1:0]                  fifo_rsv;
  csm_pkg::byte_t [`N_SLOT-1:0]          pcm_tx_nxt;
  csm_pkg::byte_t [`N_LINE-1:0]          line_tx_nxt;
  csm_pkg::byte_t [`N_FIFO-1:0]          rx_data_nxt;
  logic [`N_FIFO-1:0]                    rx_push_nxt;
  logic [`N_FIFO-1:0]                    tx_pop_nxt;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [15:0] m;
    m = old;
    if (sel[0])
    begin
      m[7:0] = d[7:0];
    end
    if (sel[1])
    begin
      m[15:8] = d[15:8];
    end
    return m;
  endfunction : merge

  function automatic csm_pkg::byte_t reverse8(input csm_pkg::byte_t b);
    csm_pkg::byte_t r;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction : reverse8

  // wishbone: one wait state, ack dropped the cycle after it is given
  assign wr_stb = cyc_i && stb_i && we_i && !ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= {16'h0000, rd_nxt};
    end
  end

  always_comb
  begin
    rd_nxt = 16'h0000;
    case (adr_i[7:4])
      `GRP_TXF: rd_nxt = 16'(txf_r[adr_i[3:2]]);
      `GRP_RXF: rd_nxt = 16'(rxf_r[adr_i[3:2]]);
      `GRP_TXS: rd_nxt = 16'(txs_r[adr_i[3:2]]);
      `GRP_RXS: rd_nxt = 16'(rxs_r[adr_i[3:2]]);
      default:
      begin
        case (adr_i)
          `REG_CTRL: rd_nxt = 16'(csm_r);
          `REG_STAT: rd_nxt = 16'(stat_r);
          `REG_MASK: rd_nxt = 16'(mask_r);
          `REG_RSV:  rd_nxt = {fifo_rsv, line_rsv};
          default:   rd_nxt = 16'h0000;
        endcase
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      csm_r  <= 1'b0;
      mask_r <= '0;
    end
    else if (wr_stb && adr_i == `REG_CTRL && sel_i[0])
    begin
      csm_r <= dat_i[`CTRL_CSM_BIT];
    end
    else if (wr_stb && adr_i == `REG_MASK && sel_i[0])
    begin
      mask_r <= dat_i[`STAT_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < `N_FIFO; i++)
      begin
        txf_r[i] <= `FIFO_CFG_RST;
        rxf_r[i] <= `FIFO_CFG_RST;
      end
      for (int i = 0; i < `N_SLOT; i++)
      begin
        txs_r[i] <= `SLOT_CFG_RST;
        rxs_r[i] <= `SLOT_CFG_RST;
      end
    end
    else if (wr_stb)
    begin
      case (adr_i[7:4])
        `GRP_TXF: txf_r[adr_i[3:2]] <= `FIFO_CFG_W'(merge(16'(txf_r[adr_i[3:2]]), dat_i,
                                                           sel_i));
        `GRP_RXF: rxf_r[adr_i[3:2]] <= `FIFO_CFG_W'(merge(16'(rxf_r[adr_i[3:2]]), dat_i,
                                                           sel_i));
        `GRP_TXS: txs_r[adr_i[3:2]] <= `SLOT_CFG_W'(merge(16'(txs_r[adr_i[3:2]]), dat_i,
                                                           sel_i));
        `GRP_RXS: rxs_r[adr_i[3:2]] <= `SLOT_CFG_W'(merge(16'(rxs_r[adr_i[3:2]]), dat_i,
                                                           sel_i));
        default: ;
      endcase
    end
  end

  // sticky events; a new event beats a write-one clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_r <= '0;
    end
    else
    begin
      for (int f = 0; f < `N_FIFO; f++)
      begin
        // overflow only flags, data path untouched
        if (tick && rx_push_nxt[f] && rx_fifo_full_i[f])
        begin
          stat_r[f] <= 1'b1;
        end
        else if (wr_stb && adr_i == `REG_STAT && sel_i[0] && dat_i[f])
        begin
          stat_r[f] <= 1'b0;
        end
      end
      if (tick)
      begin
        stat_r[`STAT_FRAME_BIT] <= 1'b1;
      end
      else if (wr_stb && adr_i == `REG_STAT && sel_i[0] && dat_i[`STAT_FRAME_BIT])
      begin
        stat_r[`STAT_FRAME_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(stat_r & mask_r);
    end
  end

  // frame counter is a parameter so a bench can shorten the 125 us frame
  assign tick = (frame_cnt_r == `FRAME_CNT_W'(FRAME_CYCLES - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
    begin
      frame_cnt_r <= '0;
    end
    else
    begin
      frame_cnt_r <= frame_cnt_r + `FRAME_CNT_W'(1);
    end
  end

  // per-fifo framing of the transmit byte
  genvar g;
  generate
    for (g = 0; g < `N_FIFO; g++)
    begin : g_tx
      tx_byte_if bif ();
      // nonzero interrupt setting enables the fifo
      assign tx_en[g]            = csm_r && (txf_r[g].irq_sel != 3'h0);
      assign rx_en[g]            = csm_r && (rxf_r[g].irq_sel != 3'h0);
      assign bif.data            = tx_fifo_data_i[g];
      assign bif.valid           = tx_fifo_valid_i[g];
      // bit order and framing per fifo
      assign bif.rev             = txf_r[g].rev;
      assign bif.transparent     = txf_r[g].transparent;
      assign bif.iff_ones        = txf_r[g].iff_ones;
      assign tx_byte[g]          = bif.out_byte;
      fill_gen u_fill (
        .bif (bif)
      );
    end
    for (g = 0; g < `N_SLOT; g++)
    begin : g_slot
      assign rx_slot_byte[g] = rxs_r[g].rout[0] ? pcm_rx_one_i[g] : pcm_rx_two_i[g];
    end
  endgenerate

  // path resolution; lowest fifo index wins when several share a channel
  always_comb
  begin
    tx_link_ch  = '0;
    rx_link_ch  = '0;
    line_rsv    = '0;
    fifo_rsv    = '0;
    pcm_tx_nxt  = '{default: `IDLE_BYTE};
    line_tx_nxt = '{default: `IDLE_BYTE};
    rx_data_nxt = '{default: `IDLE_BYTE};
    rx_push_nxt = '0;
    tx_pop_nxt  = '0;
    for (int f = 0; f < `N_FIFO; f++)
    begin
      // link-flagged fifos are held for the pcm-to-line path
      if (tx_en[f] && txf_r[f].link && !txf_r[f].dir && txf_r[f].num < `N_LINE)
      begin
        tx_link_ch[txf_r[f].num[2:0]] = 1'b1;
        fifo_rsv[f] = 1'b1;
      end
      if (rx_en[f] && rxf_r[f].link && rxf_r[f].dir && rxf_r[f].num < `N_LINE)
      begin
        rx_link_ch[rxf_r[f].num[2:0]] = 1'b1;
        fifo_rsv[`N_FIFO + f] = 1'b1;
      end
    end
    // both reserved fifos must be enabled
    link_ok = tx_link_ch & rx_link_ch;
    for (int s = `N_SLOT - 1; s >= 0; s--)
    begin
      for (int f = `N_FIFO - 1; f >= 0; f--)
      begin
        // join on equal channel number and direction
        if (txs_r[s].rout[1] && tx_en[f] && txs_r[s].num == txf_r[f].num
            && txs_r[s].dir == txf_r[f].dir)
        begin
          if (txf_r[f].link)
          begin
            // line receive goes out on the pcm transmit slot
            pcm_tx_nxt[s] = (txf_r[f].num < `N_LINE && link_ok[txf_r[f].num[2:0]])
                            ? line_rx_i[txf_r[f].num[2:0]] : `IDLE_BYTE;
          end
          else
          begin
            pcm_tx_nxt[s] = tx_byte[f];
            tx_pop_nxt[f] = tx_fifo_valid_i[f];
            // line channel blocked by fifo-to-pcm path
            if (txf_r[f].num < `N_LINE)
            begin
              line_rsv[txf_r[f].num[2:0]] = 1'b1;
            end
          end
        end
        if (rxs_r[s].rout[1] && rx_en[f] && rxs_r[s].num == rxf_r[f].num
            && rxs_r[s].dir == rxf_r[f].dir)
        begin
          // receive data still lands in the fifo
          // link data kept raw whatever the bit order select
          rx_data_nxt[f] = (rxf_r[f].rev && !rxf_r[f].link)
                           ? reverse8(rx_slot_byte[s]) : rx_slot_byte[s];
          rx_push_nxt[f] = rxf_r[f].link ? link_ok[rxf_r[f].num[2:0]] : 1'b1;
          if (rxf_r[f].link && rxf_r[f].num < `N_LINE && link_ok[rxf_r[f].num[2:0]])
          begin
            // pcm receive slot goes out on the line transmit channel
            line_tx_nxt[rxf_r[f].num[2:0]] = rx_slot_byte[s];
          end
          else if (!rxf_r[f].link && rxf_r[f].num < `N_LINE)
          begin
            line_rsv[rxf_r[f].num[2:0]] = 1'b1;
          end
        end
      end
    end
    // plain fifo-to-line and line-to-fifo on channels not taken by pcm traffic
    for (int f = `N_FIFO - 1; f >= 0; f--)
    begin
      if (tx_en[f] && !txf_r[f].link && !txf_r[f].dir && txf_r[f].num < `N_LINE
          && !line_rsv[txf_r[f].num[2:0]] && !link_ok[txf_r[f].num[2:0]])
      begin
        line_tx_nxt[txf_r[f].num[2:0]] = tx_byte[f];
        tx_pop_nxt[f] = tx_fifo_valid_i[f];
      end
      if (rx_en[f] && !rxf_r[f].link && rxf_r[f].dir && rxf_r[f].num < `N_LINE
          && !line_rsv[rxf_r[f].num[2:0]] && !rx_push_nxt[f])
      begin
        rx_data_nxt[f] = rxf_r[f].rev ? reverse8(line_rx_i[rxf_r[f].num[2:0]])
                                      : line_rx_i[rxf_r[f].num[2:0]];
        rx_push_nxt[f] = 1'b1;
      end
    end
  end

  // data outputs move once per frame; pulses last one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      frame_o        <= 1'b0;
      tx_fifo_pop_o  <= '0;
      rx_fifo_push_o <= '0;
      rx_fifo_data_o <= '{default: `IDLE_BYTE};
      line_tx_o      <= '{default: `IDLE_BYTE};
    end
    else
    begin
      frame_o        <= tick;
      tx_fifo_pop_o  <= tick ? tx_pop_nxt : '0;
      rx_fifo_push_o <= tick ? rx_push_nxt : '0;
      if (tick)
      begin
        rx_fifo_data_o <= rx_data_nxt;
        line_tx_o      <= line_tx_nxt;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pcm_tx_one_o    <= '{default: `IDLE_BYTE};
      pcm_tx_two_o    <= '{default: `IDLE_BYTE};
      pcm_tx_one_oe_o <= '0;
      pcm_tx_two_oe_o <= '0;
    end
    else if (tick)
    begin
      for (int s = 0; s < `N_SLOT; s++)
      begin
        pcm_tx_one_o[s]    <= pcm_tx_nxt[s];
        pcm_tx_two_o[s]    <= pcm_tx_nxt[s];
        pcm_tx_one_oe_o[s] <= csm_r && txs_r[s].rout[1] && !txs_r[s].rout[0];
        pcm_tx_two_oe_o[s] <= csm_r && txs_r[s].rout[1] && txs_r[s].rout[0];
      end
    end
  end

endmodule : csm_channel_routing

//--- rtl/fill_gen.sv
`include "csm_defs.svh"

module fill_gen (
  tx_byte_if.gen bif
);
  always_comb
  begin
    if (bif.valid)
    begin
      for (int i = 0; i < 8; i++)
      begin
        bif.out_byte[i] = bif.rev ? bif.data[7 - i] : bif.data[i];
      end
    end
    else if (bif.transparent)
    begin
      bif.out_byte = `IDLE_BYTE;
    end
    else
    begin
      bif.out_byte = bif.iff_ones ? `FILL_ONES : `FILL_HDLC;
    end
  end
endmodule : fill_gen

//--- test/csm_routing_checker.sv
`include "csm_defs.svh"

module csm_routing_checker #(
  parameter int FRAME_CYCLES = 16
) (
  // clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  // register bus
  input wire logic                    cyc_i,
  input wire logic                    stb_i,
  input wire logic                    ack_o,
  input wire logic [31:0]             dat_o,
  // frame side
  input wire logic                    frame_o,
  input wire logic                    irq_o,
  input wire logic [`N_FIFO-1:0]      tx_fifo_pop_o,
  input wire logic [`N_FIFO-1:0]      rx_fifo_push_o,
  input wire logic [`N_LINE-1:0][7:0] line_tx_o,
  input wire logic [`N_SLOT-1:0][7:0] pcm_tx_one_o,
  input wire logic [`N_SLOT-1:0]      pcm_tx_one_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // int wide so a long production frame cannot wrap the gap count
  int   gap_r;
  logic seen_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gap_r  <= 0;
      seen_r <= 1'b0;
    end
    else if (frame_o)
    begin
      gap_r  <= 0;
      seen_r <= 1'b1;
    end
    else
    begin
      gap_r <= gap_r + 1;
    end
  end

  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
    else $error("ack without a request");
  a_req_gets_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered after one wait state");
  a_read_hi_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_frame_single: assert property (frame_o |=> !frame_o)
    else $error("frame marker longer than one cycle");
  a_frame_period: assert property (frame_o && seen_r |-> gap_r == FRAME_CYCLES - 1)
    else $error("frame spacing wrong");
  a_pop_on_frame: assert property (|tx_fifo_pop_o |-> frame_o)
    else $error("fifo pop outside a frame edge");
  a_push_on_frame: assert property (|rx_fifo_push_o |-> frame_o)
    else $error("fifo push outside a frame edge");
  a_bytes_hold_frame: assert property (!frame_o |-> $stable(line_tx_o) && $stable(pcm_tx_one_o))
    else $error("channel bytes changed inside a frame");
  a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o && pcm_tx_one_oe_o == '0)
    else $error("outputs active after reset");

  c_frame: cover property (frame_o && seen_r);
  c_push: cover property (|rx_fifo_push_o);
  c_irq: cover property ($rose(irq_o));
endmodule : csm_routing_checker

//--- test/pcm_line_partner.sv
`include "csm_defs.svh"

module pcm_line_partner (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // frame marker from the router
  input  wire logic                    frame_i,
  // bytes sent by the pcm and line devices
  output logic      [`N_LINE-1:0][7:0] line_rx_o,
  output logic      [`N_SLOT-1:0][7:0] pcm_rx_one_o,
  output logic      [`N_SLOT-1:0][7:0] pcm_rx_two_o
);
  timeunit 1ns;
  timeprecision 1ps;

  csm_pkg::byte_t cnt_r;

  // new bytes one edge after the marker, so the sampled set stays visible
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_r <= 8'h00;
    else if (frame_i)
      cnt_r <= cnt_r + 8'h01;
  end

  always_comb
  begin
    for (int c = 0; c < `N_LINE; c++)
      line_rx_o[c] = cnt_r ^ {4'(c), 4'h9};
    for (int s = 0; s < `N_SLOT; s++)
    begin
      pcm_rx_one_o[s] = cnt_r + {4'(s), 4'h3};
      pcm_rx_two_o[s] = {cnt_r[3:0], 4'(s)};
    end
  end
endmodule : pcm_line_partner

//--- test/test_csm_channel_routing.sv
`include "csm_defs.svh"

module test_csm_channel_routing;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int FRAME_CYCLES = 16;

  logic                    clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, frame_o;
  logic [7:0]              adr_i;
  logic [3:0]              sel_i;
  logic [31:0]             dat_i, dat_o, rd;
  logic [`N_FIFO-1:0][7:0] tx_fifo_data_i, rx_fifo_data_o;
  logic [`N_FIFO-1:0]      tx_fifo_valid_i, tx_fifo_pop_o, rx_fifo_full_i, rx_fifo_push_o;
  logic [`N_LINE-1:0][7:0] line_rx_i, line_tx_o;
  logic [`N_SLOT-1:0][7:0] pcm_rx_one_i, pcm_rx_two_i, pcm_tx_one_o, pcm_tx_two_o;
  logic [`N_SLOT-1:0]      pcm_tx_one_oe_o, pcm_tx_two_oe_o;
  int                      num_errors, checks_done;

  csm_channel_routing #(.FRAME_CYCLES(FRAME_CYCLES)) uut (.*);

  pcm_line_partner far_side (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .frame_i      (frame_o),
    .line_rx_o    (line_rx_i),
    .pcm_rx_one_o (pcm_rx_one_i),
    .pcm_rx_two_o (pcm_rx_two_i)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] flip(input logic [7:0] b);
    flip = 32'h0;
    for (int i = 0; i < 8; i++)
    begin
      flip[i] = b[7 - i];
    end
  endfunction : flip

  // classic single cycle; the answer is expected after exactly one wait state
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1);
    rd = dat_o;
    // one wait state: ack is sampled at the second edge
    chk(n, 32'h2);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rd_chk

  // returns inside the cycle in which the frame marker is high
  task automatic frames(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      do
      begin
        @(posedge clk_i);
        #1;
        k++;
      end
      while (frame_o !== 1'b1);
      // a marker comes every frame, never later
      chk(32'(k <= FRAME_CYCLES), 32'h1);
    end
  endtask : frames

  initial
  begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hf;
    dat_i = 32'h0;
    tx_fifo_data_i = '0;
    tx_fifo_valid_i = '0;
    rx_fifo_full_i = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h08, 32'h0);
    wr(8'h0c, 32'hffff);
    rd_chk(8'h0c, 32'h0);
    rd_chk(8'hfc, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h30, 32'h4f);
    // hdlc fill, transparent idle, ones fill on an empty fifo
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h10, 32'h10f | ((32'h20 << i) & 32'hc0));
      frames(2);
      chk(pcm_tx_one_o[0], i == 0 ? 32'h7e : 32'hff);
      chk(pcm_tx_one_oe_o[0], 32'h1);
    end
    rd_chk(8'h0c, 32'h0);
    @(posedge clk_i);
    tx_fifo_data_i[0] <= 8'h01;
    tx_fifo_valid_i[0] <= 1'b1;
    wr(8'h10, 32'h123);
    wr(8'h30, 32'h43);
    frames(2);
    chk(tx_fifo_pop_o[0], 32'h1);
    chk(pcm_tx_one_o[0], 32'h80);
    rd_chk(8'h0c, 32'h8);
    // rx fifo 0 reversed, from rx slot 0 on pin two
    wr(8'h20, 32'h133);
    wr(8'h40, 32'h53);
    frames(2);
    chk(rx_fifo_data_o[0], flip(pcm_rx_two_i[0]));
    chk(rx_fifo_push_o[0], 32'h1);
    // pcm to line on channel 4; rx fifo full, hdlc and reversal set
    @(posedge clk_i);
    tx_fifo_valid_i[0] <= 1'b0;
    rx_fifo_full_i[1] <= 1'b1;
    wr(8'h14, 32'hf24);
    wr(8'h24, 32'hf34);
    wr(8'h34, 32'h64);
    wr(8'h44, 32'h74);
    frames(2);
    chk(pcm_tx_two_o[1], line_rx_i[4]);
    chk({pcm_tx_two_oe_o[1], pcm_tx_one_oe_o[1]}, 32'h2);
    chk(line_tx_o[4], pcm_rx_one_i[1]);
    chk(rx_fifo_push_o[1], 32'h1);
    chk(rx_fifo_data_o[1], pcm_rx_one_i[1]);
    chk(irq_o, 32'h0);
    rd_chk(8'h0c, 32'h2208);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd[1], 32'h1);
    wr(8'h08, 32'h2);
    #1;
    chk(irq_o, 32'h1);
    @(posedge clk_i);
    rx_fifo_full_i[1] <= 1'b0;
    frames(1);
    wr(8'h04, 32'h2);
    #1;
    chk(irq_o, 32'h0);
    wr(8'h24, 32'h834);
    frames(2);
    chk(line_tx_o[4], 32'hff);
    chk(pcm_tx_two_o[1], 32'hff);
    complete_run();
  end

  initial
  begin
    #(FRAME_CYCLES * 20 * 200);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
endmodule : test_csm_channel_routing

bind csm_channel_routing csm_routing_checker #(.FRAME_CYCLES(FRAME_CYCLES)) checker_i (.*);
